// [angsnt_top.v]
// Angle mapping, SENT frame transmitter and APB register file
// How it works
// - Settings bit 12 selects SENT or analog
// - Positive slope: past max angle gives high clamp
// - Positive slope: past switch angle gives low clamp
// - Negative slope swaps the two clamp levels
// - Angle maps linearly, slope sign configurable
// - Fast channel carries a 12-bit value
// - Nibble is interval between two falling edges
// - Tick period 2.7, 3, 4.5 or 6 us
// - Sync, status, data, CRC, optional pause
// - Formats A.1, H.1, A.3, H.4, H.3
// - Angle relative to zero, 180 degree period
// - Lock bit blocks all later configuration writes
// - Eight 12-bit customer storage words
// - Sync pulse lasts exactly 56 ticks
// - Status: diagnostic, pre-warning, slow channel bits
// - CRC over data, seed 0101b, two variants
// - Pause keeps frame length constant while 12 or more ticks remain for it, else the pause is 12 ticks
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "angsnt_consts.vh"

module angsnt_top #(
   parameter ANG_W = 12
) (
   input  wire             CLK_SYS_IN,
   input  wire             SYS_RST_IN,
   input  wire             PSEL_IN,
   input  wire             PENABLE_IN,
   input  wire             PWRITE_IN,
   input  wire [11:0]      PADDR_IN,
   input  wire [31:0]      PWDATA_IN,
   output wire [31:0]      PRDATA_OUT,
   output wire             PREADY_OUT,
   output wire             PSLVERR_OUT,
   input  wire [ANG_W-1:0] ANGLE_IN,
   input  wire             DIAG_IN,
   input  wire             PREWARN_IN,
   output wire             SENT_PIN_OUT,
   output wire             SENT_SEL_OUT,
   output wire [ANG_W-1:0] DAC_VALUE_OUT
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // One table step of the 4-bit checksum: shift four times, then add data
   function [3:0] angsnt_crc_step;
      input [3:0] c;
      input [3:0] d;
      integer     k;
      reg   [3:0] x;
      begin
         x = c;
         for (k = 0; k < 4; k = k + 1) begin
            if (x[3]) begin
               x = {x[2:0], 1'b0} ^ `ANGSNT_CRC_POLY;
            end else begin
               x = {x[2:0], 1'b0};
            end
         end
         angsnt_crc_step = x ^ d;
      end
   endfunction

   // Clock cycles per tick for each period selection
   function [10:0] angsnt_tick_div;
      input [1:0] sel;
      integer     q;
      begin
         case (sel)
            2'h0:    q = (`ANGSNT_TICK0_NS * `ANGSNT_CLK_MHZ) / 1000;
            2'h1:    q = (`ANGSNT_TICK1_NS * `ANGSNT_CLK_MHZ) / 1000;
            2'h2:    q = (`ANGSNT_TICK2_NS * `ANGSNT_CLK_MHZ) / 1000;
            default: q = (`ANGSNT_TICK3_NS * `ANGSNT_CLK_MHZ) / 1000;
         endcase
         // Every divisor fits eleven bits, the cut is deliberate
         angsnt_tick_div = q[10:0];
      end
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   reg  [15:0] sys_r;
   reg  [11:0] zero_r;
   reg  [11:0] maxang_r;
   reg  [11:0] swang_r;
   reg  [11:0] clhi_r;
   reg  [11:0] cllo_r;
   reg  [11:0] gain_r;
   reg         lock_r;
   reg  [11:0] oem_r [0:7];
   reg  [31:0] prdata_r;
   reg  [31:0] rd_nxt;
   reg         map_hit;
   integer     i;

   wire        acc     = PSEL_IN & PENABLE_IN;
   wire        wr      = acc & PWRITE_IN;
   wire        is_oem  = (PADDR_IN >= `ANGSNT_OFS_OEM0) && (PADDR_IN <= `ANGSNT_OFS_OEM7)
                         && (PADDR_IN[1:0] == 2'h0);
   wire [2:0]  oem_idx = PADDR_IN[4:2];
   // Status word for readback, built below from frame engine state and the mapped value
   wire [31:0] stat_w;

   // Read mux and address decode
   always @* begin
      map_hit = 1'b1;
      rd_nxt  = 32'h0;
      case (PADDR_IN)
         `ANGSNT_OFS_SYS:    rd_nxt = {16'h0, sys_r};
         `ANGSNT_OFS_ZERO:   rd_nxt = {20'h0, zero_r};
         `ANGSNT_OFS_MAXANG: rd_nxt = {20'h0, maxang_r};
         `ANGSNT_OFS_SWANG:  rd_nxt = {20'h0, swang_r};
         `ANGSNT_OFS_CLHI:   rd_nxt = {20'h0, clhi_r};
         `ANGSNT_OFS_CLLO:   rd_nxt = {20'h0, cllo_r};
         `ANGSNT_OFS_GAIN:   rd_nxt = {20'h0, gain_r};
         `ANGSNT_OFS_LOCK:   rd_nxt = {31'h0, lock_r};
         `ANGSNT_OFS_STAT:   rd_nxt = stat_w;
         default: begin
            if (is_oem) begin
               rd_nxt = {20'h0, oem_r[oem_idx]};
            end else begin
               map_hit = 1'b0;
            end
         end
      endcase
   end

   // Zero-wait slave; read data is captured in the setup cycle
   assign PREADY_OUT  = 1'b1;
   assign PRDATA_OUT  = prdata_r;
   assign PSLVERR_OUT = acc & (~map_hit | (PWRITE_IN & lock_r & (PADDR_IN != `ANGSNT_OFS_STAT)));

   // Register writes; status is read-only and writes to it are dropped
   always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         sys_r    <= `ANGSNT_RST_SYS;
         zero_r   <= 12'h000;
         maxang_r <= `ANGSNT_RST_MAXANG;
         swang_r  <= `ANGSNT_RST_SWANG;
         clhi_r   <= `ANGSNT_RST_CLHI;
         cllo_r   <= `ANGSNT_RST_CLLO;
         gain_r   <= `ANGSNT_RST_GAIN;
         lock_r   <= 1'b0;
         prdata_r <= 32'h0;
         for (i = 0; i < 8; i = i + 1) begin
            oem_r[i] <= 12'h000;
         end
      end else begin
         if (PSEL_IN & ~PENABLE_IN) begin
            prdata_r <= rd_nxt;
         end
         if (wr & ~lock_r) begin
            case (PADDR_IN)
               `ANGSNT_OFS_SYS:    sys_r    <= PWDATA_IN[15:0];
               `ANGSNT_OFS_ZERO:   zero_r   <= PWDATA_IN[11:0];
               `ANGSNT_OFS_MAXANG: maxang_r <= PWDATA_IN[11:0];
               `ANGSNT_OFS_SWANG:  swang_r  <= PWDATA_IN[11:0];
               `ANGSNT_OFS_CLHI:   clhi_r   <= PWDATA_IN[11:0];
               `ANGSNT_OFS_CLLO:   cllo_r   <= PWDATA_IN[11:0];
               `ANGSNT_OFS_GAIN:   gain_r   <= PWDATA_IN[11:0];
               `ANGSNT_OFS_LOCK:   lock_r   <= PWDATA_IN[0];
               default: begin
                  if (is_oem) begin
                     oem_r[oem_idx] <= PWDATA_IN[11:0];
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Angle to output value mapping
   // ---------------------------------------------------------------
   // Full 12-bit code spans 180 degrees, so the wrap of the subtraction gives the period
   wire [11:0] rel    = ANGLE_IN - zero_r;
   wire [23:0] prod   = rel * gain_r;
   wire [12:0] scaled = (prod[23:22] != 2'h0) ? 13'h0FFF : {1'b0, prod[21:10]};
   wire [12:0] span   = {1'b0, clhi_r} - {1'b0, cllo_r};
   wire [12:0] lin    = (scaled > span) ? span : scaled;
   wire        neg    = sys_r[`ANGSNT_B_SLOPE_NEG];
   reg  [11:0] val_nxt;
   reg  [11:0] val_r;

   // Linear region, then the two clamp regions beyond the maximum angle
   always @* begin
      if (rel <= maxang_r) begin
         val_nxt = neg ? (clhi_r - lin[11:0]) : (cllo_r + lin[11:0]);
      end else if (rel < swang_r) begin
         val_nxt = neg ? cllo_r : clhi_r;
      end else begin
         val_nxt = neg ? clhi_r : cllo_r;
      end
   end

   always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         val_r <= 12'h000;
      end else begin
         val_r <= val_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Frame builder
   // ---------------------------------------------------------------
   reg  [7:0]  loop_r;
   reg  [23:0] data_w;
   reg  [2:0]  ndata_w;
   reg  [8:0]  flen_w;
   reg  [3:0]  crc_w;
   reg  [3:0]  stat_nib;
   integer     j;
   wire [2:0]  fmt = sys_r[`ANGSNT_F_FMT_HI:`ANGSNT_F_FMT_LO];

   // D0 in the low bits; the value mapped this cycle, so no stale first frame
   always @* begin
      ndata_w = 3'h6;
      flen_w  = `ANGSNT_LEN_A1H1;
      case (fmt)
         `ANGSNT_FMT_A3, `ANGSNT_FMT_H4: begin
            data_w = {~val_nxt[11:8], loop_r[3:0], loop_r[7:4], val_nxt[3:0], val_nxt[7:4],
                      val_nxt[11:8]};
            flen_w = `ANGSNT_LEN_A3H4;
         end
         `ANGSNT_FMT_H3: begin
            data_w  = {8'h00, 1'b0, val_nxt[2:0], 1'b0, val_nxt[5:3], 1'b0, val_nxt[8:6],
                       1'b0, val_nxt[11:9]};
            ndata_w = 3'h4;
            flen_w  = `ANGSNT_LEN_H3;
         end
         default: begin
            data_w = {~val_nxt[11:8], ~val_nxt[7:4], ~val_nxt[3:0], val_nxt[3:0], val_nxt[7:4],
                      val_nxt[11:8]};
         end
      endcase
      if (sys_r[`ANGSNT_B_LEN297]) begin
         flen_w = `ANGSNT_LEN_ALL;
      end
      crc_w = `ANGSNT_CRC_SEED;
      for (j = 0; j < 6; j = j + 1) begin
         if (j < ndata_w) begin
            crc_w = angsnt_crc_step(crc_w, data_w[4*j +: 4]);
         end
      end
      if (~sys_r[`ANGSNT_B_CRC_LEGACY]) begin
         crc_w = angsnt_crc_step(crc_w, 4'h0);
      end
      stat_nib = {sys_r[`ANGSNT_B_SLOW_EN] ? sys_r[`ANGSNT_F_SLOW_HI:`ANGSNT_F_SLOW_LO] : 2'h0,
                  PREWARN_IN, DIAG_IN & sys_r[`ANGSNT_B_DIAG_EN]};
   end

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   reg         run_r;
   reg  [10:0] div_r;
   reg  [10:0] tdiv_r;
   reg  [7:0]  tick_r;
   reg  [7:0]  dur_r;
   reg  [3:0]  idx_r;
   reg  [8:0]  used_r;
   reg  [31:0] nibs_r;
   reg  [2:0]  nd_r;
   reg  [8:0]  flen_r;
   reg         pause_r;
   reg         pin_r;
   reg  [7:0]  dur_nxt;
   wire        sent_en  = sys_r[`ANGSNT_B_SENT_EN];
   wire        tick     = run_r & (div_r == tdiv_r - 11'h001);
   wire        nib_end  = tick & (tick_r == dur_r - 8'h01);
   wire [3:0]  crc_idx  = {1'b0, nd_r} + 4'h2;
   wire        last_nib = pause_r ? (idx_r == crc_idx + 4'h1) : (idx_r == crc_idx);
   wire        start    = sent_en & (~run_r | (nib_end & last_nib));
   wire [8:0]  used_nxt = used_r + {1'b0, dur_r};
   wire [3:0]  nxt_idx  = idx_r + 4'h1;
   wire [3:0]  nib_sel  = nibs_r[4*(nxt_idx - 4'h1) +: 4];

   // Length of the nibble that follows the current one
   always @* begin
      if (nxt_idx > crc_idx) begin
         // pause fills frame, never below one nibble floor
         dur_nxt = (flen_r > used_nxt + {1'b0, `ANGSNT_NIB_BASE}) ?
                   flen_r[7:0] - used_nxt[7:0] : `ANGSNT_NIB_BASE;
      end else begin
         dur_nxt = `ANGSNT_NIB_BASE + {4'h0, nib_sel};
      end
   end

   always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         run_r   <= 1'b0;
         div_r   <= 11'h000;
         tdiv_r  <= 11'h001;
         tick_r  <= 8'h00;
         dur_r   <= `ANGSNT_SYNC_TICKS;
         idx_r   <= 4'h0;
         used_r  <= 9'h000;
         nibs_r  <= 32'h0;
         nd_r    <= 3'h6;
         flen_r  <= `ANGSNT_LEN_A1H1;
         pause_r <= 1'b0;
         loop_r  <= 8'h00;
         pin_r   <= 1'b1;
      end else begin
         if (start) begin
            run_r   <= 1'b1;
            div_r   <= 11'h000;
            tdiv_r  <= angsnt_tick_div(sys_r[`ANGSNT_F_TICK_HI:`ANGSNT_F_TICK_LO]);
            tick_r  <= 8'h00;
            dur_r   <= `ANGSNT_SYNC_TICKS;
            idx_r   <= 4'h0;
            used_r  <= 9'h000;
            nd_r    <= ndata_w;
            flen_r  <= flen_w;
            pause_r <= sys_r[`ANGSNT_B_PAUSE_EN];
            nibs_r  <= ({28'h0, crc_w} << (4 * ({1'b0, ndata_w} + 4'h1)))
                       | {4'h0, data_w, stat_nib};
            loop_r  <= loop_r + 8'h01;
         end else if (~sent_en & nib_end & last_nib) begin
            // Disable takes effect only at a frame boundary
            run_r <= 1'b0;
         end else if (nib_end) begin
            div_r  <= 11'h000;
            tick_r <= 8'h00;
            idx_r  <= nxt_idx;
            used_r <= used_nxt;
            dur_r  <= dur_nxt;
         end else if (tick) begin
            div_r  <= 11'h000;
            tick_r <= tick_r + 8'h01;
         end else if (run_r) begin
            div_r <= div_r + 11'h001;
         end
         // low phase opens each nibble with a falling edge
         pin_r <= ~(start | (run_r & ~(~sent_en & nib_end & last_nib) &
                  (nib_end ? 1'b1 : (tick ? (tick_r + 8'h01 < `ANGSNT_LOW_TICKS)
                                          : (tick_r < `ANGSNT_LOW_TICKS)))));
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // pin mode select
   assign SENT_SEL_OUT  = sent_en;
   assign SENT_PIN_OUT  = pin_r;
   assign DAC_VALUE_OUT = val_r;
   assign stat_w        = {7'h0, run_r, idx_r, loop_r, val_r};

endmodule

// [angsnt_consts.vh]
// Register map, field positions, reset values and timing constants of the angle SENT transmitter
`ifndef ANGSNT_CONSTS_VH
`define ANGSNT_CONSTS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ANGSNT_OFS_SYS      12'h000
`define ANGSNT_OFS_ZERO     12'h004
`define ANGSNT_OFS_MAXANG   12'h008
`define ANGSNT_OFS_SWANG    12'h00C
`define ANGSNT_OFS_CLHI     12'h010
`define ANGSNT_OFS_CLLO     12'h014
`define ANGSNT_OFS_GAIN     12'h018
`define ANGSNT_OFS_LOCK     12'h01C
`define ANGSNT_OFS_STAT     12'h020
`define ANGSNT_OFS_OEM0     12'h040
`define ANGSNT_OFS_OEM7     12'h05C

// ---------------------------------------------------------------
// System settings word fields
// ---------------------------------------------------------------
`define ANGSNT_B_SLOPE_NEG  0
`define ANGSNT_B_CRC_LEGACY 1
`define ANGSNT_B_PAUSE_EN   2
`define ANGSNT_B_LEN297     3
`define ANGSNT_F_FMT_LO     4
`define ANGSNT_F_FMT_HI     6
`define ANGSNT_F_TICK_LO    8
`define ANGSNT_F_TICK_HI    9
`define ANGSNT_B_SLOW_EN    10
`define ANGSNT_B_DIAG_EN    11
`define ANGSNT_B_SENT_EN    12
`define ANGSNT_F_SLOW_LO    13
`define ANGSNT_F_SLOW_HI    14

// ---------------------------------------------------------------
// Format codes
// ---------------------------------------------------------------
`define ANGSNT_FMT_A1       3'h0
`define ANGSNT_FMT_H1       3'h1
`define ANGSNT_FMT_A3       3'h2
`define ANGSNT_FMT_H4       3'h3
`define ANGSNT_FMT_H3       3'h4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ANGSNT_RST_SYS      16'h1020
`define ANGSNT_RST_MAXANG   12'hFFF
`define ANGSNT_RST_SWANG    12'hFFF
`define ANGSNT_RST_CLHI     12'hFFF
`define ANGSNT_RST_CLLO     12'h000
`define ANGSNT_RST_GAIN     12'h400

// ---------------------------------------------------------------
// Timing and CRC
// ---------------------------------------------------------------
`define ANGSNT_CLK_MHZ      250
`define ANGSNT_TICK0_NS     2700
`define ANGSNT_TICK1_NS     3000
`define ANGSNT_TICK2_NS     4500
`define ANGSNT_TICK3_NS     6000
`define ANGSNT_SYNC_TICKS   8'h38
`define ANGSNT_LOW_TICKS    8'h05
`define ANGSNT_NIB_BASE     8'h0C
`define ANGSNT_LEN_A1H1     9'h0EF
`define ANGSNT_LEN_A3H4     9'h10D
`define ANGSNT_LEN_H3       9'h0C4
`define ANGSNT_LEN_ALL      9'h129
`define ANGSNT_CRC_SEED     4'h5
`define ANGSNT_CRC_POLY     4'hD

`endif

// [angsnt_checker.sv]
// Assertion checker bound to the angle SENT transmitter top
module angsnt_checker #(
   parameter ANG_W = 12
) (
   input wire logic             CLK_SYS_IN,
   input wire logic             SYS_RST_IN,
   input wire logic             PSEL_IN,
   input wire logic             PENABLE_IN,
   input wire logic             PWRITE_IN,
   input wire logic [11:0]      PADDR_IN,
   input wire logic [31:0]      PWDATA_IN,
   input wire logic             PSLVERR_OUT,
   input wire logic [ANG_W-1:0] ANGLE_IN,
   input wire logic             SENT_PIN_OUT,
   input wire logic             SENT_SEL_OUT,
   input wire logic [ANG_W-1:0] DAC_VALUE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic [15:0] sh_r [0:7];
   logic        pin_d_r;
   logic [1:0]  nfall_r;
   logic [19:0] cnt_r;
   logic [19:0] low_r;
   wire         wr_ok = PSEL_IN && PENABLE_IN && PWRITE_IN && !PSLVERR_OUT;
   wire         fall  = pin_d_r && !SENT_PIN_OUT;
   // Shadow follows accepted writes only, so a refused write leaves it alone
   always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         sh_r    <= '{16'h1020, 16'h0000, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0000, 16'h0400,
                      16'h0000};
         pin_d_r <= 1'b1;
         nfall_r <= 2'h0;
         cnt_r   <= 20'h00000;
         low_r   <= 20'h00000;
      end else begin
         if (wr_ok && PADDR_IN[11:5] == 7'h00 && PADDR_IN[1:0] == 2'h0) begin
            sh_r[PADDR_IN[4:2]] <= PWDATA_IN[15:0];
         end
         if (fall && nfall_r != 2'h3) begin
            nfall_r <= nfall_r + 2'h1;
         end
         pin_d_r <= SENT_PIN_OUT;
         cnt_r   <= fall ? 20'h00001 : cnt_r + 20'h00001;
         low_r   <= SENT_PIN_OUT ? 20'h00000 : low_r + 20'h00001;
      end
   end
   // Expected mapping; the tick length assumes no tick change mid-frame
   wire [11:0] zro  = sh_r[1][11:0];
   wire [11:0] mx   = sh_r[2][11:0];
   wire [11:0] sw   = sh_r[3][11:0];
   wire [11:0] hi   = sh_r[4][11:0];
   wire [11:0] lo   = sh_r[5][11:0];
   wire [11:0] gn   = sh_r[6][11:0];
   wire        neg  = sh_r[0][0];
   wire        lck  = sh_r[7][0];
   wire [10:0] tk   = sh_r[0][9:8] == 2'h0 ? 11'h2A3 : sh_r[0][9:8] == 2'h1 ? 11'h2EE :
                      sh_r[0][9:8] == 2'h2 ? 11'h465 : 11'h5DC;
   wire [11:0] rel  = ANGLE_IN[11:0] - zro;
   wire [23:0] prod = rel * gn;
   wire [13:0] sc   = prod[23:10];
   wire [11:0] span = hi - lo;
   wire [11:0] lin  = sc > {2'h0, span} ? span : sc[11:0];
   wire [11:0] lmap = neg ? hi - lin : lo + lin;
   wire        up   = rel > mx && rel < sw;
   wire        dn   = rel > mx && rel >= sw;
   wire [11:0] ncl  = up ? lo : hi;
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (SYS_RST_IN);
   a_sel_match: assert property (SENT_SEL_OUT == sh_r[0][12])
      else $error("output select differs from settings");
   a_lock_refuse: assert property (lck && PSEL_IN && PENABLE_IN && PWRITE_IN
      |-> PSLVERR_OUT)
      else $error("write accepted while locked");
   a_sync_len: assert property (fall && nfall_r == 2'h1 |-> cnt_r == tk * 6'h38)
      else $error("sync interval wrong");
   a_whole_ticks: assert property (fall && nfall_r != 2'h0 |->
      cnt_r % tk == 20'h0 && cnt_r >= tk * 4'hC)
      else $error("interval not whole ticks");
   a_low_time: assert property (!pin_d_r && SENT_PIN_OUT |-> low_r == tk * 3'h5)
      else $error("low phase length wrong");
   a_upper_clamp: assert property (!neg && up |=> DAC_VALUE_OUT == $past(hi))
      else $error("upper clamp missing");
   a_lower_clamp: assert property (!neg && dn |=> DAC_VALUE_OUT == $past(lo))
      else $error("lower clamp missing");
   a_neg_swap: assert property (neg && (up || dn) |=> DAC_VALUE_OUT == $past(ncl))
      else $error("clamps not swapped");
   a_linear_map: assert property (!up && !dn |=> DAC_VALUE_OUT == $past(lmap))
      else $error("linear value wrong");
   c_sync: cover property (fall && nfall_r == 2'h1);
   c_lock: cover property (lck && PSEL_IN && PENABLE_IN && PWRITE_IN);
   c_neg_up: cover property (neg && up);
endmodule

bind angsnt_top angsnt_checker #(.ANG_W(ANG_W)) angsnt_checker_inst (
   .CLK_SYS_IN    (CLK_SYS_IN),
   .SYS_RST_IN    (SYS_RST_IN),
   .PSEL_IN       (PSEL_IN),
   .PENABLE_IN    (PENABLE_IN),
   .PWRITE_IN     (PWRITE_IN),
   .PADDR_IN      (PADDR_IN),
   .PWDATA_IN     (PWDATA_IN),
   .PSLVERR_OUT   (PSLVERR_OUT),
   .ANGLE_IN      (ANGLE_IN),
   .SENT_PIN_OUT  (SENT_PIN_OUT),
   .SENT_SEL_OUT  (SENT_SEL_OUT),
   .DAC_VALUE_OUT (DAC_VALUE_OUT)
);

// [angsnt_rx_model.sv]
// SENT receiver model: times falling edges and decodes nibbles
module angsnt_rx_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int   ivl [0:15];
   int   nf;
   int   cnt;
   logic line_d_r;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nf       <= 0;
         cnt      <= 0;
         line_d_r <= 1'b1;
      end else begin
         line_d_r <= line_in;
         cnt      <= cnt + 1;
         if (line_d_r && !line_in) begin
            if (nf > 0 && nf < 17) ivl[nf - 1] <= cnt;
            nf  <= nf + 1;
            cnt <= 1;
         end
      end
   end
   function automatic int nib(input int i);
      return ivl[i] / (ivl[0] / 56) - 12;
   endfunction
endmodule

// [angsnt_top_tb.sv]
// Self-checking testbench for the angle SENT transmitter
`include "angsnt_consts.vh"
module angsnt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [11:0] angle;
   logic        diag;
   logic        prewarn;
   logic [31:0] rd;
   logic        er;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         sent_pin;
   wire         sent_sel;
   wire  [11:0] dac;
   int          fails;
   int          checked;
   int          n;
   angsnt_top #(.ANG_W(12)) angsnt_top_inst (
      .CLK_SYS_IN    (clk_sys),
      .SYS_RST_IN    (sys_rst),
      .PSEL_IN       (psel),
      .PENABLE_IN    (penable),
      .PWRITE_IN     (pwrite),
      .PADDR_IN      (paddr),
      .PWDATA_IN     (pwdata),
      .PRDATA_OUT    (prdata),
      .PREADY_OUT    (pready),
      .PSLVERR_OUT   (pslverr),
      .ANGLE_IN      (angle),
      .DIAG_IN       (diag),
      .PREWARN_IN    (prewarn),
      .SENT_PIN_OUT  (sent_pin),
      .SENT_SEL_OUT  (sent_sel),
      .DAC_VALUE_OUT (dac)
   );
   angsnt_rx_model angsnt_rx_model_inst (
      .clk_in  (clk_sys),
      .rst_in  (sys_rst),
      .line_in (sent_pin)
   );
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; answer taken at the edge that sees pready, watchdog bounds the wait
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] erd, input logic eer);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (!w) check(rd, erd);
      check({31'h0, er}, {31'h0, eer});
   endtask
   // Output value is registered, so sample well after the input moves
   task automatic map_chk(input logic [11:0] a, input logic [11:0] e);
      angle <= a;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check({20'h0, dac}, {20'h0, e});
      @(posedge clk_sys);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Clock and watchdog; a frame prefix needs about 82k cycles
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #400000;
      fails++;
      report_and_stop();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      angle = 12'h0A5;
      diag = 1'b1;
      prewarn = 1'b1;
      fails = 0;
      checked = 0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      acc(1'b0, `ANGSNT_OFS_SYS, 32'h0, 32'h1020, 1'b0);
      acc(1'b0, `ANGSNT_OFS_MAXANG, 32'h0, 32'hFFF, 1'b0);
      acc(1'b0, `ANGSNT_OFS_SWANG, 32'h0, 32'hFFF, 1'b0);
      acc(1'b0, `ANGSNT_OFS_CLLO, 32'h0, 32'h000, 1'b0);
      acc(1'b0, `ANGSNT_OFS_GAIN, 32'h0, 32'h400, 1'b0);
      acc(1'b1, `ANGSNT_OFS_SYS, 32'h0020, 32'h0, 1'b0);
      check({31'h0, sent_sel}, 32'h0);
      acc(1'b1, `ANGSNT_OFS_SYS, 32'h1020, 32'h0, 1'b0);
      check({31'h0, sent_sel}, 32'h1);
      $display("reset values and output select done");
      acc(1'b1, `ANGSNT_OFS_ZERO, 32'h100, 32'h0, 1'b0);
      acc(1'b1, `ANGSNT_OFS_MAXANG, 32'h800, 32'h0, 1'b0);
      acc(1'b1, `ANGSNT_OFS_SWANG, 32'hC00, 32'h0, 1'b0);
      acc(1'b1, `ANGSNT_OFS_CLHI, 32'hF00, 32'h0, 1'b0);
      acc(1'b1, `ANGSNT_OFS_CLLO, 32'h080, 32'h0, 1'b0);
      map_chk(12'h300, 12'h280);
      map_chk(12'h100, 12'h080);
      map_chk(12'hA00, 12'hF00);
      map_chk(12'hE00, 12'h080);
      acc(1'b1, `ANGSNT_OFS_SYS, 32'h1021, 32'h0, 1'b0);
      map_chk(12'h300, 12'hD00);
      map_chk(12'hA00, 12'h080);
      map_chk(12'hE00, 12'hF00);
      acc(1'b1, `ANGSNT_OFS_SYS, 32'h1020, 32'h0, 1'b0);
      $display("angle mapping done");
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, 12'h040 + 12'h004 * i[11:0],
             32'hABCDE000 | (i + 1) * 32'h111, 32'h0, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, 12'h040 + 12'h004 * i[11:0], 32'h0, (i + 1) * 32'h111, 1'b0);
      end
      acc(1'b0, 12'h060, 32'h0, 32'h0, 1'b1);
      $display("storage words done");
      acc(1'b1, `ANGSNT_OFS_LOCK, 32'h1, 32'h0, 1'b0);
      acc(1'b1, `ANGSNT_OFS_OEM0, 32'h5A5, 32'h0, 1'b1);
      acc(1'b0, `ANGSNT_OFS_OEM0, 32'h0, 32'h111, 1'b0);
      acc(1'b1, `ANGSNT_OFS_SYS, 32'h0020, 32'h0, 1'b1);
      check({31'h0, sent_sel}, 32'h1);
      // Still in the sync of frame one: running, index 0, loop count 1, value 0x080
      acc(1'b0, `ANGSNT_OFS_STAT, 32'h0, 32'h01001080, 1'b0);
      $display("lock done");
      n = 0;
      while (angsnt_rx_model_inst.nf < 6 && n < 90000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 90000) begin
         fails++;
      end
      check(angsnt_rx_model_inst.ivl[0], 32'd56 * 32'd675);
      check(angsnt_rx_model_inst.nib(1), 32'h2);
      check(angsnt_rx_model_inst.nib(2), 32'h0);
      check(angsnt_rx_model_inst.nib(3), 32'hA);
      check(angsnt_rx_model_inst.nib(4), 32'h5);
      $display("frame prefix done");
      report_and_stop();
   end
endmodule
